/* common/iss_pkg.sv */
// package of the two-wire bus slave status and control block: register map,
// field layouts, reset values, phase encoding and the state record.
// assumes one system clock and an avalon-mm master for register access.
package iss_pkg;

	// byte address width of the register port
	localparam int unsigned ISS_AW = 10;

	// register indexes; the byte address is four times the index
	localparam logic [7:0] ISS_IDX_OWN = 8'he3;
	localparam logic [7:0] ISS_IDX_DATA = 8'he4;
	localparam logic [7:0] ISS_IDX_CTRL = 8'he5;
	localparam logic [7:0] ISS_IDX_IEN = 8'he6;
	localparam logic [7:0] ISS_IDX_STAT = 8'he8;
	localparam logic [7:0] ISS_IDX_PREF = 8'he9;
	localparam logic [7:0] ISS_IDX_FLAG = 8'hf1;
	localparam logic [7:0] ISS_IDX_PSEL = 8'hf2;
	localparam logic [7:0] ISS_IDX_IPL = 8'hf6;

	// bus interrupt bit in the enable, flag and priority registers
	localparam int unsigned ISS_IRQ_BIT = 3;
	// fields of the pin-select register
	localparam int unsigned ISS_PSEL_AFIL = 6;
	localparam int unsigned ISS_PSEL_DFIL = 5;
	localparam int unsigned ISS_PSEL_PAIR_HI = 4;
	localparam int unsigned ISS_PSEL_PAIR_LO = 3;
	// pin pair without edge-rate control, open-drain automatically
	localparam logic [1:0] ISS_PAIR_OD = 2'h1;

	// scl rising-edge counts inside one byte frame
	localparam logic [3:0] ISS_CNT_LAST = 4'h8;
	localparam logic [3:0] ISS_CNT_ACK = 4'h9;
	// system clocks from the interrupt to the prefetch move
	localparam logic [1:0] ISS_PF_DELAY = 2'h2;

	// status register, bit 7 down to bit 0
	typedef struct packed {
		logic start;
		logic stop;
		logic rw;
		logic ad;
		logic bf;
		logic ack;
		logic wcol;
		logic recov;
	} iss_status_t;

	// control register, bit 5 down to bit 0
	typedef struct packed {
		logic soft_rst;
		logic rd_str;
		logic wr_str;
		logic clock_hold_release;
		logic edge_rate_off;
		logic en;
	} iss_ctrl_t;

	localparam iss_status_t ISS_STAT_RST = 8'h44;
	localparam iss_ctrl_t ISS_CTRL_RST = 6'h10;
	localparam logic [6:0] ISS_PSEL_RST = 7'h40;

	typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_RX, PH_TX, PH_SKIP} iss_phase_t;

	// avalon-mm request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [ISS_AW-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} iss_avs_req_t;

	typedef struct packed {
		logic [2:0] scl_sy;
		logic [2:0] sda_sy;
		logic scl_f;
		logic sda_f;
		iss_ctrl_t ctrl;
		iss_status_t stat;
		logic [6:0] own_addr;
		logic [7:0] data;
		logic [7:0] prefetch;
		logic [7:0] txsh;
		logic [7:0] rxsh;
		logic [3:0] cnt;
		iss_phase_t phase;
		logic [1:0] pf_cnt;
		logic sda_low;
		logic irq_en;
		logic irq_flag;
		logic irq_prio;
		logic [6:0] pinsel;
		logic waitreq;
		logic [7:0] rdata;
		logic scl_oe_n;
		logic sda_oe_n;
		logic slew_limit_en;
		logic open_drain_en;
		logic afil_en;
		logic dfil_en;
		logic [1:0] pin_pair;
		logic irq_req;
		logic irq_high;
		logic pin_lvl;
	} iss_state_t;

	localparam iss_state_t ISS_STATE_RST = '{
		scl_sy: 3'h7, sda_sy: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
		ctrl: ISS_CTRL_RST, stat: ISS_STAT_RST, phase: PH_IDLE,
		pinsel: ISS_PSEL_RST, waitreq: 1'b1, scl_oe_n: 1'b1, sda_oe_n: 1'b1,
		slew_limit_en: 1'b1, afil_en: 1'b1, default: '0};

endpackage

/* logic/iss_top.sv */
// two-wire bus slave with status, stretch and prefetch logic, registers on avalon-mm.
// assumes scl/sda are open-drain wires resolved outside; pins are asynchronous.
`timescale 1ns/1ns
module iss_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire iss_pkg::iss_avs_req_t avs_req,
	output logic avs_waitrequest,
	output logic [31:0] avs_readdata,
	input wire logic scl_in,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe_n,
	output logic slew_limit_en,
	output logic open_drain_en,
	output logic analog_filter_select,
	output logic digital_filter_select,
	output logic [1:0] pin_pair_sel,
	output logic bus_irq_req,
	output logic bus_irq_high
);
	import iss_pkg::*;

	iss_state_t q;
	iss_state_t d;
	logic scl_fn;
	logic sda_fn;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic bus_req;
	logic bus_done;
	logic [7:0] bus_idx;
	logic [7:0] bus_wb;
	logic cpu_ok;
	logic [7:0] rd_byte;
	logic ack_ev;
	logic irq_ev;
	logic tx_start;
	logic rx_byte_ev;

	// the digital filter only accepts a level seen on two samples in a row
	assign scl_fn = (!q.pinsel[ISS_PSEL_DFIL] || q.scl_sy[1] == q.scl_sy[2]) ?
		q.scl_sy[1] : q.scl_f;
	assign sda_fn = (!q.pinsel[ISS_PSEL_DFIL] || q.sda_sy[1] == q.sda_sy[2]) ?
		q.sda_sy[1] : q.sda_f;
	assign scl_rise = scl_fn && !q.scl_f;
	assign scl_fall = !scl_fn && q.scl_f;
	assign start_ev = q.ctrl.en && q.scl_f && scl_fn && q.sda_f && !sda_fn;
	assign stop_ev = q.ctrl.en && q.scl_f && scl_fn && !q.sda_f && sda_fn;
	assign rx_byte_ev = q.ctrl.en && !q.ctrl.soft_rst && scl_fall && q.cnt == ISS_CNT_LAST &&
		q.phase == PH_RX;

	assign bus_req = avs_req.read || avs_req.write;
	assign bus_done = bus_req && !q.waitreq;
	assign bus_idx = avs_req.address[ISS_AW-1:2];
	assign bus_wb = avs_req.writedata[7:0];
	assign cpu_ok = q.stat.rw && q.ctrl.rd_str && !q.ctrl.clock_hold_release;

	always_comb begin
		d = q;
		ack_ev = 1'b0;
		irq_ev = 1'b0;
		tx_start = 1'b0;
		rd_byte = 8'h00;
		d.scl_sy = {q.scl_sy[1:0], scl_in};
		d.sda_sy = {q.sda_sy[1:0], sda_in};
		d.scl_f = scl_fn;
		d.sda_f = sda_fn;

		case (bus_idx)
			ISS_IDX_OWN: rd_byte = {q.own_addr, 1'b0};
			ISS_IDX_DATA: rd_byte = q.data;
			ISS_IDX_CTRL: rd_byte = {2'b00, q.ctrl};
			ISS_IDX_IEN: rd_byte = 8'(q.irq_en) << ISS_IRQ_BIT;
			ISS_IDX_STAT: rd_byte = q.stat;
			ISS_IDX_PREF: rd_byte = q.prefetch;
			ISS_IDX_FLAG: rd_byte = 8'(q.irq_flag) << ISS_IRQ_BIT;
			ISS_IDX_PSEL: rd_byte = {1'b0, q.pinsel};
			ISS_IDX_IPL: rd_byte = 8'(q.irq_prio) << ISS_IRQ_BIT;
			default: rd_byte = 8'h00;
		endcase

		// one wait cycle per access; the access acts on the edge that sees waitrequest low
		d.waitreq = !(bus_req && q.waitreq);
		if (bus_req && q.waitreq) begin
			d.rdata = rd_byte;
		end
		if (bus_done && avs_req.write && avs_req.byteenable[0]) begin
			case (bus_idx)
				ISS_IDX_OWN: d.own_addr = bus_wb[7:1];
				ISS_IDX_DATA: begin
					if (cpu_ok) begin
						d.data = bus_wb;
						d.txsh = bus_wb;
						d.stat.bf = 1'b1;
						d.sda_low = !bus_wb[7];
					end else begin
						d.stat.wcol = 1'b1;
					end
				end
				ISS_IDX_CTRL: d.ctrl = iss_ctrl_t'(bus_wb[5:0]);
				ISS_IDX_IEN: d.irq_en = bus_wb[ISS_IRQ_BIT];
				ISS_IDX_STAT: begin
					// the upper six bits belong to hardware alone
					d.stat.wcol = bus_wb[1];
					d.stat.recov = bus_wb[0];
				end
				ISS_IDX_PREF: d.prefetch = bus_wb;
				ISS_IDX_FLAG: d.irq_flag = bus_wb[ISS_IRQ_BIT];
				ISS_IDX_PSEL: d.pinsel = bus_wb[6:0];
				ISS_IDX_IPL: d.irq_prio = bus_wb[ISS_IRQ_BIT];
				default: ;
			endcase
		end
		if (bus_done && avs_req.read && bus_idx == ISS_IDX_DATA) begin
			d.stat.bf = 1'b0;
		end

		// prefetch move runs on system clocks while the master waits in the ack low time
		if (q.pf_cnt != 2'h0) begin
			d.pf_cnt = q.pf_cnt - 2'h1;
			if (q.pf_cnt == 2'h1) begin
				d.data = q.prefetch;
				d.txsh = q.prefetch;
				d.stat.bf = 1'b1;
				d.sda_low = !q.prefetch[7];
			end
		end

		if (q.ctrl.en) begin
			if (start_ev) begin
				d.stat.start = 1'b1;
				d.stat.stop = 1'b0;
				d.stat.ack = 1'b0;
				d.stat.rw = 1'b0;
				d.phase = PH_ADDR;
				d.cnt = 4'h0;
				d.sda_low = 1'b0;
				d.pf_cnt = 2'h0;
			end else if (stop_ev) begin
				d.stat.stop = 1'b1;
				d.stat.start = 1'b0;
				d.stat.rw = 1'b0;
				d.phase = PH_IDLE;
				d.cnt = 4'h0;
				d.sda_low = 1'b0;
			end else if (q.phase != PH_IDLE && q.phase != PH_SKIP) begin
				if (scl_rise) begin
					if (q.cnt < ISS_CNT_LAST) begin
						d.rxsh = {q.rxsh[6:0], sda_fn};
						d.cnt = q.cnt + 4'h1;
					end else if (q.cnt == ISS_CNT_LAST) begin
						d.cnt = ISS_CNT_ACK;
						d.stat.ack = sda_fn;
						ack_ev = 1'b1;
						if (q.phase == PH_TX && sda_fn) begin
							d.stat.rw = 1'b0;
						end
					end
				end else if (scl_fall) begin
					if (q.cnt == ISS_CNT_LAST) begin
						case (q.phase)
							PH_ADDR: begin
								if (q.rxsh[7:1] == q.own_addr) begin
									d.stat.ad = 1'b0;
									d.sda_low = 1'b1;
								end else begin
									d.phase = PH_SKIP;
								end
							end
							PH_RX: begin
								d.stat.ad = 1'b1;
								d.sda_low = 1'b1;
								if (d.stat.bf) begin
									d.stat.recov = 1'b1;
								end else begin
									d.data = q.rxsh;
									d.stat.bf = 1'b1;
								end
							end
							default: begin
								// byte fully shifted out, hand sda to the master for its ack
								d.stat.ad = 1'b1;
								d.stat.bf = 1'b0;
								d.sda_low = 1'b0;
							end
						endcase
					end else if (q.cnt == ISS_CNT_ACK) begin
						d.cnt = 4'h0;
						d.sda_low = 1'b0;
						irq_ev = 1'b1;
						case (q.phase)
							PH_ADDR: begin
								d.stat.rw = q.rxsh[0];
								d.phase = q.rxsh[0] ? PH_TX : PH_RX;
								tx_start = q.rxsh[0];
								if (!q.rxsh[0] && q.ctrl.wr_str) begin
									d.ctrl.clock_hold_release = 1'b0;
								end
							end
							PH_RX: begin
								if (q.ctrl.wr_str) begin
									d.ctrl.clock_hold_release = 1'b0;
								end
							end
							default: begin
								// a nack ends the read; no stretch, wait for stop
								if (q.stat.ack) begin
									d.phase = PH_SKIP;
								end else begin
									tx_start = 1'b1;
								end
							end
						endcase
					end else if (q.phase == PH_TX && q.cnt != 4'h0) begin
						d.txsh = {q.txsh[6:0], 1'b0};
						d.sda_low = !q.txsh[6];
					end
				end
			end
			if (irq_ev) begin
				d.irq_flag = 1'b1;
			end
			if (tx_start) begin
				if (q.ctrl.rd_str) begin
					d.ctrl.clock_hold_release = 1'b0;
				end else begin
					d.pf_cnt = ISS_PF_DELAY;
				end
			end
		end

		if (q.ctrl.soft_rst) begin
			// control register stays on the global reset so software can leave soft reset
			d.stat = ISS_STAT_RST;
			d.own_addr = 7'h00;
			d.data = 8'h00;
			d.prefetch = 8'h00;
			d.txsh = 8'h00;
			d.rxsh = 8'h00;
			d.cnt = 4'h0;
			d.phase = PH_IDLE;
			d.pf_cnt = 2'h0;
			d.sda_low = 1'b0;
		end

		d.scl_oe_n = !(d.ctrl.en && !d.ctrl.clock_hold_release);
		d.sda_oe_n = !(d.ctrl.en && d.sda_low);
		d.pin_pair = d.pinsel[ISS_PSEL_PAIR_HI:ISS_PSEL_PAIR_LO];
		d.open_drain_en = d.pin_pair == ISS_PAIR_OD;
		d.slew_limit_en = !d.ctrl.edge_rate_off && !d.open_drain_en;
		d.afil_en = d.pinsel[ISS_PSEL_AFIL];
		d.dfil_en = d.pinsel[ISS_PSEL_DFIL];
		d.irq_req = d.irq_flag && d.irq_en;
		d.irq_high = d.irq_req && d.irq_prio;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= ISS_STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign avs_waitrequest = q.waitreq;
	assign avs_readdata = {24'h000000, q.rdata};
	assign scl_o = q.pin_lvl;
	assign sda_o = q.pin_lvl;
	assign scl_oe_n = q.scl_oe_n;
	assign sda_oe_n = q.sda_oe_n;
	assign slew_limit_en = q.slew_limit_en;
	assign open_drain_en = q.open_drain_en;
	assign analog_filter_select = q.afil_en;
	assign digital_filter_select = q.dfil_en;
	assign pin_pair_sel = q.pin_pair;
	assign bus_irq_req = q.irq_req;
	assign bus_irq_high = q.irq_high;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_bad_dwrite;
		bus_done && avs_req.write && avs_req.byteenable[0] && bus_idx == ISS_IDX_DATA &&
			!cpu_ok && !q.ctrl.soft_rst;
	endsequence

	sequence s_pf_arm;
		tx_start && !q.ctrl.rd_str && !q.ctrl.soft_rst;
	endsequence

	sequence s_pf_walk;
		q.pf_cnt == 2'h2 ##1 q.pf_cnt == 2'h1 ##1 q.txsh == $past(q.prefetch);
	endsequence

	property p_hold_low;
		q.ctrl.en && !q.ctrl.clock_hold_release |-> !scl_oe_n;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("scl not held");

	property p_start_seen;
		start_ev && !q.ctrl.soft_rst |=> q.stat.start && !q.stat.stop && !q.stat.ack;
	endproperty
	a_start_seen: assert property (p_start_seen) else $error("start not flagged");

	property p_stop_seen;
		stop_ev && !q.ctrl.soft_rst |=> q.stat.stop && !q.stat.start && !q.stat.rw;
	endproperty
	a_stop_seen: assert property (p_stop_seen) else $error("stop not flagged");

	property p_wcol;
		s_bad_dwrite |=> q.stat.wcol;
	endproperty
	a_wcol: assert property (p_wcol) else $error("collision not flagged");

	property p_prefetch;
		s_pf_arm |=> s_pf_walk;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("prefetch move late");

	property p_ack_sample;
		ack_ev && !q.ctrl.soft_rst |=> q.stat.ack == q.sda_f;
	endproperty
	a_ack_sample: assert property (p_ack_sample) else $error("ack sample wrong");

	property p_irq;
		irq_ev && !q.ctrl.soft_rst |=> q.irq_flag && (bus_irq_req == q.irq_en);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_rd_stretch;
		tx_start && q.ctrl.rd_str && !q.ctrl.soft_rst |=> !q.ctrl.clock_hold_release &&
			!scl_oe_n;
	endproperty
	a_rd_stretch: assert property (p_rd_stretch) else $error("read stretch missing");

	property p_overrun;
		rx_byte_ev && q.stat.bf && !bus_done |=> q.stat.recov && q.data == $past(q.data);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun mishandled");

	property p_bf_read;
		bus_done && avs_req.read && bus_idx == ISS_IDX_DATA && !rx_byte_ev &&
			q.pf_cnt != 2'h1 && !q.ctrl.soft_rst |=> !q.stat.bf;
	endproperty
	a_bf_read: assert property (p_bf_read) else $error("full flag not cleared");

	property p_slew;
		q.ctrl.edge_rate_off || q.open_drain_en |-> !slew_limit_en;
	endproperty
	a_slew: assert property (p_slew) else $error("edge rate wrong");

endmodule

/* tb/iss_master_model.sv */
// master side of the two-wire bus: start, stop, byte write and byte read.
// assumes open-drain wires resolved by the bench with pull-ups.
`timescale 1ns/1ns
module iss_master_model (
	input wire logic clk,
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_m,
	output logic sda_m
);
	// scl stands still between frames
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	// one scl pulse of eight clocks; waits out slave stretching, samples mid-high
	task automatic pulse(output logic s);
		int n;
		n = 0;
		repeat (2) @(posedge clk);
		scl_m <= 1'b1;
		@(posedge clk);
		while (scl_w !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		repeat (2) @(posedge clk);
		s = sda_w;
		repeat (2) @(posedge clk);
		scl_m <= 1'b0;
		// sda moves one clock after the fall, never with it
		@(posedge clk);
	endtask
	task automatic start_cond();
		sda_m <= 1'b1;
		scl_m <= 1'b1;
		repeat (4) @(posedge clk);
		sda_m <= 1'b0;
		repeat (4) @(posedge clk);
		scl_m <= 1'b0;
		@(posedge clk);
	endtask
	task automatic stop_cond();
		sda_m <= 1'b0;
		repeat (2) @(posedge clk);
		scl_m <= 1'b1;
		repeat (4) @(posedge clk);
		sda_m <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// msb first, then the acknowledge slot with sda released
	task automatic wr_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			sda_m <= v[i];
			pulse(s);
		end
		sda_m <= 1'b1;
		pulse(ack);
	endtask
	task automatic rd_byte(input logic nack, output logic [7:0] v);
		logic s;
		sda_m <= 1'b1;
		for (int i = 7; i >= 0; i--) begin
			pulse(s);
			v[i] = s;
		end
		sda_m <= nack;
		// sda stays at the acknowledge level; the next start, stop or byte moves it
		pulse(s);
	endtask
endmodule

/* tb/tb.sv */
// bench of the two-wire slave block: registers over avalon-mm, transfers by the master model.
// assumes one wait edge per register access and pull-ups on both wires.
`timescale 1ns/1ns
module tb;
	import iss_pkg::*;
	logic clk;
	logic sys_rst;
	iss_avs_req_t req;
	logic avs_waitrequest;
	logic [31:0] avs_readdata;
	logic scl_o, scl_oe_n, sda_o, sda_oe_n, slew, odrain, afil, dfil, irq_req, irq_high;
	logic [1:0] pair;
	logic scl_m, sda_m, ack;
	logic [7:0] rd, b;
	int errors, samples_checked;
	logic [15:0] rst_tab [10] = '{16'he510, 16'he844, 16'hf240, 16'he600, 16'hf100,
		16'hf600, 16'he300, 16'he400, 16'he900, 16'h1000};
	wire scl_w = scl_m & (scl_oe_n | scl_o);
	wire sda_w = sda_m & (sda_oe_n | sda_o);
	wire [9:0] pins = {scl_oe_n, sda_oe_n, slew, odrain, afil, dfil, pair, irq_req, irq_high};
	iss_top dut (.clk(clk), .sys_rst(sys_rst), .avs_req(req), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .scl_in(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
		.sda_in(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .slew_limit_en(slew),
		.open_drain_en(odrain), .analog_filter_select(afil), .digital_filter_select(dfil),
		.pin_pair_sel(pair), .bus_irq_req(irq_req), .bus_irq_high(irq_high));
	iss_master_model m (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic reg_acc(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		req.read <= ~wr;
		req.write <= wr;
		req.address <= {idx, 2'h0};
		req.writedata <= {24'h0, wd};
		req.byteenable <= 4'hf;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 200);
		// read data stands at the very edge that sees waitrequest low
		rd = avs_readdata[7:0];
		req.read <= 1'b0;
		req.write <= 1'b0;
		// one idle edge so the next request is not assigned in the same step
		@(posedge clk);
		if (n >= 200) begin
			errors++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		reg_acc(1'b1, idx, d);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		reg_acc(1'b0, idx, 8'h00);
		chk({2'h0, rd}, {2'h0, exp});
	endtask
	// pins are registered and bus events lag the wires by the synchronisers
	task automatic pin_chk(input logic [9:0] mask, input logic [9:0] exp);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(pins & mask, exp);
		@(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	initial begin
		req = '0;
		sys_rst = 1'b1;
		errors = 0;
		samples_checked = 0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		foreach (rst_tab[i]) rd_chk(rst_tab[i][15:8], rst_tab[i][7:0]);
		pin_chk(10'h3ff, 10'h3a0);
		wr(ISS_IDX_STAT, 8'hff);
		rd_chk(ISS_IDX_STAT, 8'h47);
		wr(ISS_IDX_STAT, 8'h00);
		wr(8'h10, 8'hff);
		rd_chk(8'h10, 8'h00);
		rd_chk(ISS_IDX_STAT, 8'h44);
		wr(ISS_IDX_PSEL, 8'h28);
		pin_chk(10'h0fc, 10'h054);
		wr(ISS_IDX_PSEL, 8'h50);
		pin_chk(10'h0fc, 10'h0a8);
		wr(ISS_IDX_PSEL, 8'h40);
		wr(ISS_IDX_CTRL, 8'h12);
		pin_chk(10'h080, 10'h000);
		wr(ISS_IDX_CTRL, 8'h10);
		pin_chk(10'h080, 10'h080);
		wr(ISS_IDX_FLAG, 8'h08);
		rd_chk(ISS_IDX_FLAG, 8'h08);
		pin_chk(10'h003, 10'h000);
		wr(ISS_IDX_IEN, 8'h08);
		pin_chk(10'h003, 10'h002);
		wr(ISS_IDX_IPL, 8'h08);
		pin_chk(10'h003, 10'h003);
		wr(ISS_IDX_FLAG, 8'h00);
		pin_chk(10'h003, 10'h000);
		wr(ISS_IDX_IPL, 8'h00);
		// master write with both stretch modes on
		wr(ISS_IDX_OWN, 8'h54);
		wr(ISS_IDX_CTRL, 8'h1d);
		m.start_cond();
		m.wr_byte(8'h54, ack);
		chk({9'h0, ack}, 10'h000);
		pin_chk(10'h200, 10'h000);
		rd_chk(ISS_IDX_STAT, 8'h80);
		rd_chk(ISS_IDX_CTRL, 8'h19);
		rd_chk(ISS_IDX_FLAG, 8'h08);
		wr(ISS_IDX_FLAG, 8'h00);
		wr(ISS_IDX_CTRL, 8'h1d);
		pin_chk(10'h200, 10'h200);
		m.wr_byte(8'ha5, ack);
		pin_chk(10'h200, 10'h000);
		rd_chk(ISS_IDX_STAT, 8'h98);
		wr(ISS_IDX_DATA, 8'h00);
		rd_chk(ISS_IDX_STAT, 8'h9a);
		wr(ISS_IDX_STAT, 8'h00);
		wr(ISS_IDX_CTRL, 8'h1d);
		m.wr_byte(8'h3c, ack);
		pin_chk(10'h200, 10'h000);
		rd_chk(ISS_IDX_STAT, 8'h99);
		rd_chk(ISS_IDX_DATA, 8'ha5);
		rd_chk(ISS_IDX_STAT, 8'h91);
		wr(ISS_IDX_STAT, 8'h00);
		wr(ISS_IDX_CTRL, 8'h1d);
		m.stop_cond();
		rd_chk(ISS_IDX_STAT, 8'h50);
		// foreign address: no acknowledge, no stretch, status changed only by the start
		m.start_cond();
		m.wr_byte(8'h22, ack);
		chk({9'h0, ack}, 10'h001);
		pin_chk(10'h200, 10'h200);
		rd_chk(ISS_IDX_STAT, 8'h90);
		m.stop_cond();
		// master read with read-stretch
		m.start_cond();
		m.wr_byte(8'h55, ack);
		chk({9'h0, ack}, 10'h000);
		pin_chk(10'h200, 10'h000);
		rd_chk(ISS_IDX_STAT, 8'ha0);
		rd_chk(ISS_IDX_CTRL, 8'h19);
		wr(ISS_IDX_DATA, 8'h96);
		rd_chk(ISS_IDX_STAT, 8'ha8);
		wr(ISS_IDX_CTRL, 8'h1d);
		m.rd_byte(1'b1, b);
		chk({2'h0, b}, 10'h096);
		pin_chk(10'h200, 10'h200);
		rd_chk(ISS_IDX_STAT, 8'h94);
		m.stop_cond();
		rd_chk(ISS_IDX_STAT, 8'h54);
		// master read fed from the prefetch register, no stretch
		wr(ISS_IDX_CTRL, 8'h05);
		wr(ISS_IDX_PREF, 8'hc3);
		m.start_cond();
		m.wr_byte(8'h55, ack);
		pin_chk(10'h200, 10'h200);
		m.rd_byte(1'b1, b);
		chk({2'h0, b}, 10'h0c3);
		m.stop_cond();
		wr(ISS_IDX_CTRL, 8'h35);
		wr(ISS_IDX_CTRL, 8'h15);
		rd_chk(ISS_IDX_STAT, 8'h44);
		rd_chk(ISS_IDX_PREF, 8'h00);
		rd_chk(ISS_IDX_OWN, 8'h00);
		rd_chk(ISS_IDX_CTRL, 8'h15);
		report_and_stop();
	end
endmodule
